// >>> verilog/irq_ctrl_defines.svh
// constants of the two-level vectored interrupt controller
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

`define IRQ_NUM_SRC       15
`define IRQ_SRC_W         4
// register byte addresses on the avalon bus
`define IRQ_ADDR_GEN_EN   8'h00
`define IRQ_ADDR_T2_EN    8'he8
`define IRQ_ADDR_PRIO_LO  8'h04
`define IRQ_ADDR_PRIO_HI  8'h08
`define IRQ_ADDR_FLAGS    8'h0c
`define IRQ_ADDR_FLAG_SET 8'h10
`define IRQ_ADDR_FLAG_CLR 8'h14
`define IRQ_ADDR_STATUS   8'h18
`define IRQ_ADDR_EXT_MODE 8'h1c
`define IRQ_RESET_BYTE    8'h00
`define IRQ_GLOBAL_BIT    7
// machine cycle phase at which request flags are sampled (s5p2)
`define IRQ_PHASE_CNT     4'd12
`define IRQ_SAMPLE_PHASE  4'd9
// vector base and spacing
`define IRQ_VEC_BASE      16'h0003
`define IRQ_VEC_STEP_SH   3
// source indices, vector order
`define SRC_EXT0  4'd0
`define SRC_TMR0  4'd1
`define SRC_EXT1  4'd2
`define SRC_TMR1  4'd3
`define SRC_UART  4'd4
`define SRC_TWI   4'd5
`define SRC_CAP0  4'd6
`define SRC_CAP1  4'd7
`define SRC_CAP2  4'd8
`define SRC_CAP3  4'd9
`define SRC_ADC   4'd10
`define SRC_CMP0  4'd11
`define SRC_CMP1  4'd12
`define SRC_CMP2  4'd13
`define SRC_T2_WORD_OVERFLOW_FLAG  4'd14

`endif

// >>> verilog/irq_ctrl_pkg.sv
// types of the two-level vectored interrupt controller
package irq_ctrl_pkg;

    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } avl_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avl_rsp_type;

    typedef struct packed {
        logic        last_cycle;
        logic        reti_exec;
        logic        irq_reg_access;
    } core_status_type;

    typedef struct packed {
        logic        call;
        logic [15:0] vector;
        logic [3:0]  source;
    } core_call_type;

endpackage

// >>> verilog/irq_sync.sv
// two-stage synchroniser for asynchronous request inputs
`timescale 1ns/1ps
`default_nettype none

module irq_sync #(
    parameter int WIDTH = 15
) (
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    input  wire logic             enable_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_type;

    sync_state_type state_reg;
    sync_state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (enable_i) begin
            state_next.stage1 = async_i;
            state_next.stage2 = state_reg.stage1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_o = state_reg.stage2;
endmodule

`default_nettype wire

// >>> verilog/irq_arbiter.sv
// two-level priority arbiter with fixed polling order
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.svh"

module irq_arbiter #(
    parameter int NSRC = 15
) (
    input  wire logic [NSRC-1:0] pending_i,
    input  wire logic [NSRC-1:0] prio_i,
    input  wire logic            active_lo_i,
    input  wire logic            active_hi_i,
    output logic                 valid_o,
    output logic                 level_o,
    output logic [3:0]           source_o
);
    // polling order, highest first, given as vector-order indices
    localparam logic [3:0] POLL [0:14] = '{
        `SRC_EXT0, `SRC_TWI, `SRC_ADC, `SRC_TMR0, `SRC_CAP0, `SRC_CMP0,
        `SRC_EXT1, `SRC_CAP1, `SRC_CMP1, `SRC_TMR1, `SRC_CAP2, `SRC_CMP2,
        `SRC_UART, `SRC_CAP3, `SRC_T2_WORD_OVERFLOW_FLAG};

    logic [NSRC-1:0] hi_req;
    logic [NSRC-1:0] lo_req;
    logic            hi_ok;
    logic            lo_ok;

    assign hi_req = pending_i & prio_i;
    assign lo_req = pending_i & ~prio_i;
    assign hi_ok  = !active_hi_i;
    assign lo_ok  = !active_hi_i && !active_lo_i;

    always_comb begin
        valid_o  = 1'b0;
        level_o  = 1'b0;
        source_o = 4'h0;
        // walk from lowest to highest so the earliest poll entry wins
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (lo_ok && lo_req[POLL[i]]) begin
                valid_o  = 1'b1;
                level_o  = 1'b0;
                source_o = POLL[i];
            end
        end
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (hi_ok && hi_req[POLL[i]]) begin
                valid_o  = 1'b1;
                level_o  = 1'b1;
                source_o = POLL[i];
            end
        end
    end
endmodule

`default_nettype wire

// >>> verilog/irq_ctrl.sv
// two-level vectored interrupt controller with avalon register port
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.svh"

module irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int NSRC = `IRQ_NUM_SRC
) (
    input  wire logic                           clock_i,
    input  wire logic                           nrst_i,
    input  wire logic                           clk_en_i,
    input  wire irq_ctrl_pkg::avl_req_type      avl_i,
    output      irq_ctrl_pkg::avl_rsp_type      avl_o,
    input  wire irq_ctrl_pkg::core_status_type  core_i,
    input  wire logic                           call_ack_i,
    output      irq_ctrl_pkg::core_call_type    call_o,
    input  wire logic [NSRC-1:0]                hw_set_i,
    input  wire logic                           t2_byte_overflow_flag_i,
    input  wire logic                           t2_word_overflow_flag_i,
    input  wire logic [1:0]                     ext_level_n_i,
    output logic [NSRC-1:0]                     flags_o
);
    import irq_ctrl_pkg::*;

    typedef enum {
        st_idle,
        st_call,
        st_holdoff
    } call_state_type;

    typedef struct packed {
        call_state_type    state;
        logic [3:0]        phase;
        logic [7:0]        general_irq_enable_reg;
        logic [7:0]        timer2_event_irq_enable_reg;
        logic [7:0]        priority_select_low_reg;
        logic [7:0]        priority_select_high_reg;
        logic [1:0]        ext_edge_mode;
        logic [NSRC-1:0]   flags;
        logic [NSRC-1:0]   sampled;
        logic              sample_valid;
        logic              active_lo;
        logic              active_hi;
        logic              holdoff_pend;
        logic              last_d;
        avl_rsp_type       rsp;
        core_call_type     call;
    } ctrl_state_type;

    ctrl_state_type   s_reg;
    ctrl_state_type   s_next;
    logic [NSRC-1:0]  hw_sync;
    logic [1:0]       ext_sync;
    logic [NSRC-1:0]  enables;
    logic [NSRC-1:0]  prio;
    logic [NSRC-1:0]  pending;
    logic             arb_valid;
    logic             arb_level;
    logic [3:0]       arb_src;
    logic             bus_wr;
    logic             bus_rd;

    // ********************************************************
    // input synchronisers
    // ********************************************************
    irq_sync #(
        .WIDTH (NSRC + 2)
    ) u_sync (
        .clock_i  (clock_i),
        .nrst_i   (nrst_i),
        .enable_i (clk_en_i),
        // pins inverted ahead of the sync so its reset value is the idle level
        .async_i  ({~ext_level_n_i, hw_set_i}),
        .sync_o   ({ext_sync, hw_sync})
    );

    // ********************************************************
    // register layout helpers
    // ********************************************************
    // map an 8-bit pair of registers onto vector-order source bits
    function automatic logic [NSRC-1:0] map_bits(input logic [7:0] gen,
                                                 input logic [7:0] t2);
        logic [NSRC-1:0] m;
        m = '0;
        m[`SRC_EXT0] = gen[0];
        m[`SRC_TMR0] = gen[1];
        m[`SRC_EXT1] = gen[2];
        m[`SRC_TMR1] = gen[3];
        m[`SRC_UART] = gen[4];
        m[`SRC_TWI]  = gen[5];
        m[`SRC_ADC]  = gen[6];
        m[`SRC_CAP0] = t2[0];
        m[`SRC_CAP1] = t2[1];
        m[`SRC_CAP2] = t2[2];
        m[`SRC_CAP3] = t2[3];
        m[`SRC_CMP0] = t2[4];
        m[`SRC_CMP1] = t2[5];
        m[`SRC_CMP2] = t2[6];
        m[`SRC_T2_WORD_OVERFLOW_FLAG] = t2[7];
        return m;
    endfunction

    function automatic logic is_reg_addr(input logic [7:0] a);
        return (a == `IRQ_ADDR_GEN_EN) || (a == `IRQ_ADDR_T2_EN) ||
               (a == `IRQ_ADDR_PRIO_LO) || (a == `IRQ_ADDR_PRIO_HI);
    endfunction

    assign enables = map_bits(s_reg.general_irq_enable_reg,
                              s_reg.timer2_event_irq_enable_reg)
                     & {NSRC{s_reg.general_irq_enable_reg[`IRQ_GLOBAL_BIT]}};
    // priority: low register holds legacy sources, high register timer2 group
    assign prio    = map_bits(s_reg.priority_select_low_reg, s_reg.priority_select_high_reg);
    // only the latest sample is polled, nothing older
    assign pending = s_reg.sample_valid ? (s_reg.sampled & enables) : '0;

    irq_arbiter #(
        .NSRC (NSRC)
    ) u_arb (
        .pending_i   (pending),
        .prio_i      (prio),
        .active_lo_i (s_reg.active_lo),
        .active_hi_i (s_reg.active_hi),
        .valid_o     (arb_valid),
        .level_o     (arb_level),
        .source_o    (arb_src)
    );

    assign bus_wr = avl_i.write && s_reg.rsp.waitrequest;
    assign bus_rd = avl_i.read && s_reg.rsp.waitrequest;

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        logic [NSRC-1:0] set_v;
        logic [NSRC-1:0] clr_v;
        logic [NSRC-1:0] ack_clr;
        logic [31:0]     rd;
        logic            acc;
        set_v   = '0;
        clr_v   = '0;
        ack_clr = '0;
        rd      = '0;
        acc     = 1'b0;
        s_next  = s_reg;
        if (clk_en_i) begin
            // every access takes one wait cycle, then completes
            s_next.rsp.waitrequest = 1'b1;
            if (bus_wr || bus_rd) begin
                s_next.rsp.waitrequest = 1'b0;
                acc = is_reg_addr(avl_i.address);
            end
            // a write lands at the edge where the master sees waitrequest low
            if (avl_i.write && !s_reg.rsp.waitrequest) begin
                if (avl_i.address == `IRQ_ADDR_GEN_EN) begin
                    s_next.general_irq_enable_reg = avl_i.writedata[7:0];
                end else if (avl_i.address == `IRQ_ADDR_T2_EN) begin
                    s_next.timer2_event_irq_enable_reg = avl_i.writedata[7:0];
                end else if (avl_i.address == `IRQ_ADDR_PRIO_LO) begin
                    s_next.priority_select_low_reg = avl_i.writedata[7:0];
                end else if (avl_i.address == `IRQ_ADDR_PRIO_HI) begin
                    s_next.priority_select_high_reg = avl_i.writedata[7:0];
                end else if (avl_i.address == `IRQ_ADDR_EXT_MODE) begin
                    s_next.ext_edge_mode = avl_i.writedata[1:0];
                end else if (avl_i.address == `IRQ_ADDR_FLAG_SET) begin
                    set_v = avl_i.writedata[NSRC-1:0];
                    set_v[`SRC_ADC] = 1'b0;
                end else if (avl_i.address == `IRQ_ADDR_FLAG_CLR) begin
                    clr_v = avl_i.writedata[NSRC-1:0];
                end
            end
            if (bus_rd) begin
                if (avl_i.address == `IRQ_ADDR_GEN_EN) begin
                    rd[7:0] = s_reg.general_irq_enable_reg;
                end else if (avl_i.address == `IRQ_ADDR_T2_EN) begin
                    rd[7:0] = s_reg.timer2_event_irq_enable_reg;
                end else if (avl_i.address == `IRQ_ADDR_PRIO_LO) begin
                    rd[7:0] = s_reg.priority_select_low_reg;
                end else if (avl_i.address == `IRQ_ADDR_PRIO_HI) begin
                    rd[7:0] = s_reg.priority_select_high_reg;
                end else if (avl_i.address == `IRQ_ADDR_EXT_MODE) begin
                    rd[1:0] = s_reg.ext_edge_mode;
                end else if (avl_i.address == `IRQ_ADDR_FLAGS) begin
                    rd[NSRC-1:0] = s_reg.flags;
                end else if (avl_i.address == `IRQ_ADDR_STATUS) begin
                    rd[2:0] = {s_reg.state != st_idle, s_reg.active_hi, s_reg.active_lo};
                end
            end
            s_next.rsp.readdata = rd;

            // machine cycle timing, sample at s5p2
            s_next.phase = (s_reg.phase == `IRQ_PHASE_CNT - 4'd1) ? 4'h0 : s_reg.phase + 4'd1;
            if (s_reg.phase == `IRQ_SAMPLE_PHASE) begin
                s_next.sampled      = s_reg.flags;
                s_next.sample_valid = 1'b1;
            end

            // register access or reti holds off until another instruction ends
            if (acc || core_i.irq_reg_access || core_i.reti_exec) begin
                s_next.holdoff_pend = 1'b1;
            end
            s_next.last_d = core_i.last_cycle;

            case (s_reg.state)
                st_idle: begin
                    if (s_reg.holdoff_pend || acc || core_i.irq_reg_access || core_i.reti_exec) begin
                        s_next.state = st_holdoff;
                    end else if (arb_valid && core_i.last_cycle) begin
                        s_next.call.call   = 1'b1;
                        s_next.call.source = arb_src;
                        s_next.call.vector = `IRQ_VEC_BASE
                            + (16'(arb_src) << `IRQ_VEC_STEP_SH);
                        s_next.sample_valid = 1'b0;
                        if (arb_level) begin
                            s_next.active_hi = 1'b1;
                        end else begin
                            s_next.active_lo = 1'b1;
                        end
                        if (arb_src == `SRC_TMR0 || arb_src == `SRC_TMR1) begin
                            ack_clr[arb_src] = 1'b1;
                        end
                        if (arb_src == `SRC_EXT0 && s_reg.ext_edge_mode[0]) begin
                            ack_clr[arb_src] = 1'b1;
                        end
                        if (arb_src == `SRC_EXT1 && s_reg.ext_edge_mode[1]) begin
                            ack_clr[arb_src] = 1'b1;
                        end
                        s_next.state = st_call;
                    end
                end
                st_call: begin
                    // the core performs the push of pc and jump
                    if (call_ack_i) begin
                        s_next.call.call = 1'b0;
                        s_next.state     = st_idle;
                    end
                end
                st_holdoff: begin
                    // release once last_d shows the core was in an instruction's last cycle on the previous clock
                    s_next.holdoff_pend = 1'b0;
                    if (s_reg.last_d && !core_i.reti_exec && !core_i.irq_reg_access && !acc) begin
                        s_next.state = st_idle;
                    end else begin
                        s_next.holdoff_pend = 1'b0;
                    end
                end
                default: begin
                    s_next.state = st_idle;
                end
            endcase

            // reti clears the highest active level
            if (core_i.reti_exec) begin
                if (s_reg.active_hi) begin
                    s_next.active_hi = 1'b0;
                end else begin
                    s_next.active_lo = 1'b0;
                end
            end

            // level triggered external inputs set their flag while the pin is low
            set_v[`SRC_EXT0] = set_v[`SRC_EXT0] | (!s_reg.ext_edge_mode[0] & ext_sync[0]);
            set_v[`SRC_EXT1] = set_v[`SRC_EXT1] | (!s_reg.ext_edge_mode[1] & ext_sync[1]);
            set_v[`SRC_T2_WORD_OVERFLOW_FLAG] = set_v[`SRC_T2_WORD_OVERFLOW_FLAG] | t2_byte_overflow_flag_i
                               | t2_word_overflow_flag_i;
            // hardware set wins over any clear in the same cycle
            s_next.flags = (s_reg.flags & ~(clr_v | ack_clr)) | set_v | hw_sync;
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            s_reg       <= '0;
            s_reg.state <= st_idle;
            s_reg.rsp   <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign avl_o   = s_reg.rsp;
    assign call_o  = s_reg.call;
    assign flags_o = s_reg.flags;

    // ********************************************************
    // checks
    // ********************************************************
    property p_vec_spacing;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(call_o.call) |-> call_o.vector == (16'h0003 + {call_o.source, 3'b000});
    endproperty
    a_vec_spacing: assert property (p_vec_spacing) else $error("bad vector");

    property p_call_last;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(call_o.call) |-> $past(core_i.last_cycle);
    endproperty
    a_call_last: assert property (p_call_last) else $error("call not at last cycle");

    property p_hi_no_preempt;
        @(posedge clock_i) disable iff (!nrst_i)
        s_reg.active_hi && !core_i.reti_exec |=> !$rose(call_o.call);
    endproperty
    a_hi_no_preempt: assert property (p_hi_no_preempt) else $error("high preempted");

    property p_reti_holdoff;
        @(posedge clock_i) disable iff (!nrst_i)
        core_i.reti_exec && clk_en_i |=> !$rose(call_o.call);
    endproperty
    a_reti_holdoff: assert property (p_reti_holdoff) else $error("call after reti");

    property p_global;
        @(posedge clock_i) disable iff (!nrst_i)
        !s_reg.general_irq_enable_reg[7] && s_reg.state == st_idle |=> !$rose(call_o.call);
    endproperty
    a_global: assert property (p_global) else $error("call while disabled");

    property p_reset_zero;
        @(posedge clock_i)
        !nrst_i |=> s_reg.general_irq_enable_reg == 8'h00 && s_reg.priority_select_low_reg == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset not zero");

    property p_t2_word_overflow_flag;
        @(posedge clock_i) disable iff (!nrst_i)
        clk_en_i && t2_byte_overflow_flag_i |=> flags_o[14];
    endproperty
    a_t2_word_overflow_flag: assert property (p_t2_word_overflow_flag) else $error("t2 overflow flag lost");

    property p_adc_no_sw_set;
        @(posedge clock_i) disable iff (!nrst_i)
        clk_en_i && !s_reg.flags[10] && !hw_sync[10] |=> !flags_o[10];
    endproperty
    a_adc_no_sw_set: assert property (p_adc_no_sw_set) else $error("adc set by sw");
endmodule

`default_nettype wire

// >>> bench/core_model.sv
// behavioural processor core: instruction timing, call acknowledge and reti
`timescale 1ns/1ps
`default_nettype none

module core_model (
    input  wire logic                         clock_i,
    input  wire logic                         nrst_i,
    input  wire irq_ctrl_pkg::core_call_type  call_i,
    input  wire logic                         reti_i,
    output var  irq_ctrl_pkg::core_status_type core_o,
    output logic                              call_ack_o
);
    import irq_ctrl_pkg::*;
    logic [3:0] phase;
    logic       mcyc;
    logic       len2;
    logic       pend;
    logic       fire;
    int         depth;
    // ****
    // one- and two-cycle instructions alternate
    // ****
    always_comb begin
        core_o = '0;
        core_o.last_cycle = (mcyc == len2);
        core_o.reti_exec = fire;
    end
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            phase <= 4'h0;
            mcyc <= 1'b0;
            len2 <= 1'b0;
            pend <= 1'b0;
            fire <= 1'b0;
            depth <= 0;
            call_ack_o <= 1'b0;
        end else begin
            phase <= (phase == 4'hb) ? 4'h0 : phase + 4'h1;
            fire <= 1'b0;
            call_ack_o <= call_i.call && !call_ack_o;
            // each taken call stacks the pc, no status word
            if (call_i.call && !call_ack_o) depth <= depth + 1;
            if (reti_i) pend <= 1'b1;
            if (phase == 4'hb) begin
                mcyc <= (mcyc == len2) ? 1'b0 : 1'b1;
                if (mcyc == len2) len2 <= ~len2;
                // reti only completes at an instruction boundary
                if (mcyc == len2 && pend && depth > 0) begin
                    fire <= 1'b1;
                    pend <= 1'b0;
                    depth <= depth - 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench of the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defines.svh"

module tb_top;
    import irq_ctrl_pkg::*;
    logic            clock_i;
    logic            nrst_i;
    avl_req_type     avl_i;
    avl_rsp_type     avl_o;
    core_status_type core_i;
    core_call_type   call_o;
    logic            call_ack_i;
    logic [14:0]     hw_set_i;
    logic            t2_byte;
    logic            t2_word;
    logic [1:0]      ext_n;
    logic [14:0]     flags_o;
    logic            reti;
    logic            call_d;
    logic [31:0]     rd_q[$];
    logic [31:0]     vec_q[$];
    int              err_total;
    int              checks_done;
    int              acks;
    int              want;
    int              seed;
    int              poll[15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};

    irq_ctrl irq_ctrl_i (.clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .avl_i(avl_i),
        .avl_o(avl_o), .core_i(core_i), .call_ack_i(call_ack_i), .call_o(call_o),
        .hw_set_i(hw_set_i), .t2_byte_overflow_flag_i(t2_byte),
        .t2_word_overflow_flag_i(t2_word), .ext_level_n_i(ext_n), .flags_o(flags_o));
    core_model core_model_i (.clock_i(clock_i), .nrst_i(nrst_i), .call_i(call_o),
        .reti_i(reti), .core_o(core_i), .call_ack_o(call_ack_i));

    // ****
    // helpers
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic rd, input logic [31:0] d);
        @(posedge clock_i);
        avl_i <= '{address: a, read: rd, write: !rd, writedata: d};
        do begin
            @(posedge clock_i);
        end while (avl_o.waitrequest !== 1'b0);
        avl_i <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(a, 1'b1, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b0, d);
    endtask
    task automatic expect_src(input int s);
        vec_q.push_back(32'h3 + 32'(s) * 8);
    endtask
    task automatic raise(input logic [14:0] m, input logic [1:0] t2);
        @(posedge clock_i);
        hw_set_i <= m;
        {t2_word, t2_byte} <= t2;
        @(posedge clock_i);
        hw_set_i <= '0;
        {t2_word, t2_byte} <= 2'b00;
    endtask
    task automatic wait_ack();
        want++;
        while (acks < want) begin
            @(posedge clock_i);
        end
        repeat (4) @(posedge clock_i);
    endtask
    task automatic finish_isr(input int s);
        wr(`IRQ_ADDR_FLAG_CLR, 32'h1 << s);
        reti <= 1'b1;
        @(posedge clock_i);
        reti <= 1'b0;
        repeat (40) @(posedge clock_i);
    endtask
    // {timer2 enable, general enable} bits that unmask one source alone
    function automatic logic [15:0] en_of(input int s);
        if (s < 6) return {8'h00, 8'h80 | (8'h01 << s)};
        if (s == 10) return 16'h00c0;
        if (s < 10) return {8'h01 << (s - 6), 8'h80};
        if (s < 14) return {8'h01 << (s - 7), 8'h80};
        return 16'h8080;
    endfunction

    // ****
    // result watcher and stimulus
    // ****
    always @(posedge clock_i) begin
        call_d <= call_o.call;
        if (call_ack_i === 1'b1) acks <= acks + 1;
        if (avl_i.read && avl_o.waitrequest === 1'b0 && rd_q.size() > 0)
            check(avl_o.readdata, rd_q.pop_front());
        if (call_o.call === 1'b1 && !call_d) begin
            // a call nobody expected can never match the all-ones note
            if (vec_q.size() > 0) check({16'h0, call_o.vector}, vec_q.pop_front());
            else check({16'h0, call_o.vector}, 32'hffffffff);
        end
    end
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    initial begin
        #400000;
        err_total++;
        wrap_up();
    end
    initial begin
        int a;
        int b;
        logic [31:0] v;
        {nrst_i, reti, t2_byte, t2_word} = '0;
        avl_i = '0;
        hw_set_i = '0;
        ext_n = 2'b11;
        seed = 32'ha91a8cf6;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        foreach (poll[i]) if (i < 4) rd(8'h00 + 8'(i) * 4, 32'h0);
        rd(`IRQ_ADDR_T2_EN, 32'h0);
        wr(8'h20, 32'hff);
        rd(8'h20, 32'h0);
        v = {24'h0, 8'($random(seed))};
        wr(`IRQ_ADDR_T2_EN, v);
        rd(`IRQ_ADDR_T2_EN, v);
        $display("test registers done");
        wr(`IRQ_ADDR_EXT_MODE, 32'h3);
        for (int s = 0; s < 15; s++) begin
            wr(`IRQ_ADDR_GEN_EN, {24'h0, en_of(s)[7:0]});
            wr(`IRQ_ADDR_T2_EN, {24'h0, en_of(s)[15:8]});
            expect_src(s);
            raise(15'h1 << s, 2'b00);
            wait_ack();
            check({31'h0, flags_o[s]}, (s < 4) ? 32'h0 : 32'h1);
            finish_isr(s);
        end
        for (int k = 0; k < 2; k++) begin
            expect_src(14);
            raise('0, 2'b01 << k);
            wait_ack();
            finish_isr(14);
        end
        $display("test vectors done");
        wr(`IRQ_ADDR_GEN_EN, 32'hff);
        wr(`IRQ_ADDR_T2_EN, 32'hff);
        repeat (5) begin
            a = $unsigned($random(seed)) % 14;
            b = a + 1 + $unsigned($random(seed)) % (14 - a);
            expect_src(poll[a]);
            expect_src(poll[b]);
            raise((15'h1 << poll[a]) | (15'h1 << poll[b]), 2'b00);
            wait_ack();
            finish_isr(poll[a]);
            wait_ack();
            finish_isr(poll[b]);
        end
        $display("test poll order done");
        wr(`IRQ_ADDR_FLAG_SET, 32'h1 << 10);
        repeat (4) @(posedge clock_i);
        check({31'h0, flags_o[10]}, 32'h0);
        expect_src(4);
        wr(`IRQ_ADDR_FLAG_SET, 32'h1 << 4);
        wait_ack();
        finish_isr(4);
        wr(`IRQ_ADDR_GEN_EN, 32'h7f);
        wr(`IRQ_ADDR_FLAG_SET, 32'h1 << 4);
        repeat (60) @(posedge clock_i);
        check({31'h0, call_o.call}, 32'h0);
        wr(`IRQ_ADDR_FLAG_CLR, 32'h1 << 4);
        wr(`IRQ_ADDR_GEN_EN, 32'hff);
        $display("test software flags done");
        wr(`IRQ_ADDR_EXT_MODE, 32'h0);
        expect_src(0);
        ext_n <= 2'b10;
        wait_ack();
        check({31'h0, flags_o[0]}, 32'h1);
        ext_n <= 2'b11;
        repeat (2) @(posedge clock_i);
        finish_isr(0);
        $display("test level input done");
        wr(`IRQ_ADDR_PRIO_HI, 32'h81);
        expect_src(14);
        expect_src(5);
        raise((15'h1 << 5) | (15'h1 << 14), 2'b00);
        wait_ack();
        raise(15'h1 << 4, 2'b00);
        repeat (60) @(posedge clock_i);
        check({31'h0, call_o.call}, 32'h0);
        wr(`IRQ_ADDR_FLAG_CLR, 32'h1 << 4);
        finish_isr(14);
        wait_ack();
        expect_src(6);
        raise(15'h1 << 6, 2'b00);
        wait_ack();
        finish_isr(6);
        finish_isr(5);
        repeat (60) @(posedge clock_i);
        check(vec_q.size(), 32'h0);
        $display("test priority levels done");
        wrap_up();
    end
endmodule
`default_nettype wire
